// ### vcw_regs.sv
// Command register slice: protection level, format info, rail targets.
// Assumes the command decoder presents one command per cycle at most,
// and that page and operation bytes and limit words come from their own owners.
//
// Behaviour
// - Level 40h: only four commands stay writable.
// - Level 20h: also on-off, target, offset writable.
// - Level resets to 00h; 00h allows all.
// - Other level values raise invalid data fault.
// - Format info is read-only and reads 40h.
// - Level and format info are shared by pages.
// - Target word resets 0384h, used on nominal source.
// - Target is held between minimum and maximum.
// - Signed offset word, reset 0000h, within 250 mV.
// - Target and offset words kept per rail.
// - Page 00h rail 0, 01h rail 1, FFh both.
// - Source field 00 selects the target word.
`timescale 1ns/1ps

module vcw_regs
	import vcw_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire vcw_byte_t cmdCode,
	input wire vcw_word_t cmdData,
	input wire vcw_byte_t pageSel,
	input wire vcw_byte_t operation0,
	input wire vcw_byte_t operation1,
	input wire vcw_word_t voutMin0,
	input wire vcw_word_t voutMin1,
	input wire vcw_word_t voutMax0,
	input wire vcw_word_t voutMax1,
	output logic rspValid,
	output vcw_word_t rspData,
	output logic rspHit,
	output logic wrAccepted,
	output logic wrRejected,
	output logic invalidDataFault,
	output vcw_byte_t protLevel,
	output vcw_word_t target0,
	output vcw_word_t target1,
	output logic targetUse0,
	output logic targetUse1
);

	// Decoded request.
	logic isWp;
	logic isMode;
	logic isCmd;
	logic isTrim;
	logic isHit;
	logic allowed;
	logic [`VCW_RAILS-1:0] pageRails;
	logic wrReq;
	logic rdReq;

	// Protection level group.
	vcw_byte_t level_r;
	vcw_byte_t level_nxt;

	// Rail store hookup.
	logic [`VCW_RAILS-1:0] storeWr;
	vcw_sel_e storeSel;
	vcw_word_t storeRd;
	vcw_word_t cmdWord [`VCW_RAILS];
	vcw_word_t trimWord [`VCW_RAILS];
	vcw_word_t railMin [`VCW_RAILS];
	vcw_word_t railMax [`VCW_RAILS];
	vcw_byte_t railOp [`VCW_RAILS];
	vcw_word_t railTarget [`VCW_RAILS];
	logic railUse [`VCW_RAILS];

	// First response stage group.
	logic s1Valid_r;
	logic s1Valid_nxt;
	logic s1Write_r;
	logic s1Write_nxt;
	vcw_byte_t s1Code_r;
	vcw_byte_t s1Code_nxt;
	logic s1Hit_r;
	logic s1Hit_nxt;
	logic s1Acc_r;
	logic s1Acc_nxt;
	logic s1Fault_r;
	logic s1Fault_nxt;
	vcw_byte_t s1Level_r;
	vcw_byte_t s1Level_nxt;

	// Output stage group.
	logic rspValid_r;
	logic rspValid_nxt;
	vcw_word_t rspData_r;
	vcw_word_t rspData_nxt;
	logic rspHit_r;
	logic rspHit_nxt;
	logic wrAcc_r;
	logic wrAcc_nxt;
	logic wrRej_r;
	logic wrRej_nxt;
	logic fault_r;
	logic fault_nxt;

	// Which commands the current level still lets through.
	function automatic logic wr_allowed(input vcw_byte_t lvl,
		input vcw_byte_t code);
		logic always_ok;
		logic cfg_ok;
		always_ok = (code == `VCW_CODE_WP) ||
			(code == `VCW_CODE_OPERATION) ||
			(code == `VCW_CODE_CLEAR) || (code == `VCW_CODE_PAGE);
		cfg_ok = (code == `VCW_CODE_ONOFF) || (code == `VCW_CODE_CMD) ||
			(code == `VCW_CODE_TRIM);
		case (lvl)
			`VCW_WP_LOCK: wr_allowed = always_ok;
			`VCW_WP_CFG: wr_allowed = always_ok || cfg_ok;
			`VCW_WP_ALL: wr_allowed = 1'b1;
			default: wr_allowed = always_ok;
		endcase
	endfunction : wr_allowed

	// Request decode, page to rails and protection check.
	always_comb begin
		isWp = (cmdCode == `VCW_CODE_WP);
		isMode = (cmdCode == `VCW_CODE_MODE);
		isCmd = (cmdCode == `VCW_CODE_CMD);
		isTrim = (cmdCode == `VCW_CODE_TRIM);
		isHit = isWp || isMode || isCmd || isTrim;
		pageRails[0] = (pageSel == `VCW_PAGE_R0) ||
			(pageSel == `VCW_PAGE_BOTH);
		pageRails[1] = (pageSel == `VCW_PAGE_R1) ||
			(pageSel == `VCW_PAGE_BOTH);
		allowed = wr_allowed(level_r, cmdCode);
		wrReq = cmdValid && cmdWrite;
		rdReq = cmdValid && !cmdWrite;
	end

	// Rail store writes only when allowed and a rail is paged.
	always_comb begin
		storeSel = isTrim ? VCW_SEL_TRIM : VCW_SEL_CMD;
		storeWr = '0;
		if (wrReq && allowed && (isCmd || isTrim)) begin
			storeWr = pageRails;
		end
	end

	vcw_rail_store uStore (
		.mclk(mclk),
		.srst(srst),
		.wrRail(storeWr),
		.wrSel(storeSel),
		.wrData(cmdData),
		.rdEn(rdReq && (isCmd || isTrim)),
		.rdRail(pageSel == `VCW_PAGE_R1),
		.rdSel(storeSel),
		.rdData(storeRd),
		.cmdWord(cmdWord),
		.trimWord(trimWord)
	);

	// One target calculator per rail.
	assign railMin[0] = voutMin0;
	assign railMin[1] = voutMin1;
	assign railMax[0] = voutMax0;
	assign railMax[1] = voutMax1;
	assign railOp[0] = operation0;
	assign railOp[1] = operation1;
	for (genvar g = 0; g < `VCW_RAILS; g++) begin : gCalc
		vcw_target_calc uCalc (
			.mclk(mclk),
			.srst(srst),
			.cmdMv(cmdWord[g]),
			.trimMv(trimWord[g]),
			.minMv(railMin[g]),
			.maxMv(railMax[g]),
			.operation(railOp[g]),
			.target(railTarget[g]),
			.useCmd(railUse[g])
		);
	end

	// The level is one shared copy; illegal values are dropped.
	always_comb begin
		level_nxt = level_r;
		if (wrReq && isWp && allowed && vcw_level_legal(cmdData[7:0])) begin
			level_nxt = cmdData[7:0];
		end
	end

	// Protection level register.
	always_ff @(posedge mclk) begin
		if (srst) begin
			level_r <= `VCW_WP_RST;
		end else begin
			level_r <= level_nxt;
		end
	end

	// First stage records the outcome while the store reads.
	always_comb begin
		s1Valid_nxt = cmdValid;
		s1Write_nxt = cmdWrite;
		s1Code_nxt = cmdCode;
		s1Hit_nxt = isHit;
		s1Level_nxt = level_r;
		s1Fault_nxt = wrReq && isWp &&
			!vcw_level_legal(cmdData[7:0]);
		s1Acc_nxt = wrReq && allowed;
		if (wrReq && isMode) begin
			s1Acc_nxt = 1'b0;
		end
		if (wrReq && (isCmd || isTrim) && (pageRails == '0)) begin
			s1Acc_nxt = 1'b0;
		end
		if (s1Fault_nxt) begin
			s1Acc_nxt = 1'b0;
		end
	end

	// First stage registers.
	always_ff @(posedge mclk) begin
		if (srst) begin
			s1Valid_r <= 1'b0;
			s1Write_r <= 1'b0;
			s1Code_r <= 8'h00;
			s1Hit_r <= 1'b0;
			s1Acc_r <= 1'b0;
			s1Fault_r <= 1'b0;
			s1Level_r <= 8'h00;
		end else begin
			s1Valid_r <= s1Valid_nxt;
			s1Write_r <= s1Write_nxt;
			s1Code_r <= s1Code_nxt;
			s1Hit_r <= s1Hit_nxt;
			s1Acc_r <= s1Acc_nxt;
			s1Fault_r <= s1Fault_nxt;
			s1Level_r <= s1Level_nxt;
		end
	end

	// Output stage builds the answer pulse and read data.
	always_comb begin
		rspValid_nxt = s1Valid_r;
		rspHit_nxt = s1Valid_r && s1Hit_r;
		wrAcc_nxt = s1Valid_r && s1Write_r && s1Acc_r;
		wrRej_nxt = s1Valid_r && s1Write_r && !s1Acc_r;
		fault_nxt = s1Valid_r && s1Fault_r;
		rspData_nxt = 16'h0000;
		if (s1Valid_r && !s1Write_r) begin
			case (s1Code_r)
				`VCW_CODE_WP: rspData_nxt = {8'h00, s1Level_r};
				`VCW_CODE_MODE: rspData_nxt = {8'h00, `VCW_MODE_VAL};
				`VCW_CODE_CMD: rspData_nxt = storeRd;
				`VCW_CODE_TRIM: rspData_nxt = storeRd;
				default: rspData_nxt = 16'h0000;
			endcase
		end
	end

	// Output stage registers.
	always_ff @(posedge mclk) begin
		if (srst) begin
			rspValid_r <= 1'b0;
			rspData_r <= 16'h0000;
			rspHit_r <= 1'b0;
			wrAcc_r <= 1'b0;
			wrRej_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			rspValid_r <= rspValid_nxt;
			rspData_r <= rspData_nxt;
			rspHit_r <= rspHit_nxt;
			wrAcc_r <= wrAcc_nxt;
			wrRej_r <= wrRej_nxt;
			fault_r <= fault_nxt;
		end
	end

	// Outputs straight from registers.
	assign rspValid = rspValid_r;
	assign rspData = rspData_r;
	assign rspHit = rspHit_r;
	assign wrAccepted = wrAcc_r;
	assign wrRejected = wrRej_r;
	assign invalidDataFault = fault_r;
	assign protLevel = level_r;
	assign target0 = railTarget[0];
	assign target1 = railTarget[1];
	assign targetUse0 = railUse[0];
	assign targetUse1 = railUse[1];

endmodule : vcw_regs

// ### vcw_cfg.svh
// Constants for the output-voltage command slice of the register bank.
// Assumes it is included by the package, ahead of the design modules that use its macros.
`ifndef VCW_CFG_SVH
`define VCW_CFG_SVH

// Command codes that this slice decodes or must recognise.
`define VCW_CODE_PAGE 8'h00
`define VCW_CODE_OPERATION 8'h01
`define VCW_CODE_ONOFF 8'h02
`define VCW_CODE_CLEAR 8'h03
`define VCW_CODE_WP 8'h10
`define VCW_CODE_MODE 8'h20
`define VCW_CODE_CMD 8'h21
`define VCW_CODE_TRIM 8'h22

// Protection levels, the reset level and the fixed format value.
`define VCW_WP_ALL 8'h00
`define VCW_WP_CFG 8'h20
`define VCW_WP_LOCK 8'h40
`define VCW_WP_RST 8'h00
`define VCW_MODE_VAL 8'h40

// Reset values of the per-rail words and the trim span in millivolts.
`define VCW_CMD_RST 16'h0384
`define VCW_TRIM_RST 16'h0000
`define VCW_TRIM_LIM 16'h00FA

// Page selections and the target source field of the operation byte.
`define VCW_PAGE_R0 8'h00
`define VCW_PAGE_R1 8'h01
`define VCW_PAGE_BOTH 8'hFF
`define VCW_OP_SRC_HI 5
`define VCW_OP_SRC_LO 4
`define VCW_SRC_CMD 2'h0

// Number of output rails.
`define VCW_RAILS 2

`endif

// ### vcw_pkg.sv
// Types and shared decoding for the output-voltage command slice.
// Assumes the constants header is reachable by its bare name.
`include "vcw_cfg.svh"

package vcw_pkg;

	typedef logic [7:0] vcw_byte_t;
	typedef logic [15:0] vcw_word_t;

	// One-hot choice of the per-rail word held in the rail store.
	typedef enum logic [1:0] {
		VCW_SEL_CMD = 2'b01,
		VCW_SEL_TRIM = 2'b10
	} vcw_sel_e;

	// True for the three protection levels that the bank accepts.
	function automatic logic vcw_level_legal(input vcw_byte_t lvl);
		vcw_level_legal = (lvl == `VCW_WP_ALL) || (lvl == `VCW_WP_CFG) ||
			(lvl == `VCW_WP_LOCK);
	endfunction : vcw_level_legal

endpackage : vcw_pkg

// ### vcw_rail_store.sv
// Per-rail storage of the commanded voltage and the trim offset.
// Assumes one write and one read request per cycle from the bank.
`timescale 1ns/1ps

module vcw_rail_store
	import vcw_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [`VCW_RAILS-1:0] wrRail,
	input wire vcw_sel_e wrSel,
	input wire vcw_word_t wrData,
	input wire logic rdEn,
	input wire logic rdRail,
	input wire vcw_sel_e rdSel,
	output vcw_word_t rdData,
	output vcw_word_t cmdWord [`VCW_RAILS],
	output vcw_word_t trimWord [`VCW_RAILS]
);

	vcw_word_t cmd_r [`VCW_RAILS];
	vcw_word_t trim_r [`VCW_RAILS];
	vcw_word_t rdData_r;
	vcw_word_t rdData_nxt;

	// Each rail keeps its own copy; a write lands only on selected rails.
	for (genvar g = 0; g < `VCW_RAILS; g++) begin : gRail
		vcw_word_t cmd_nxt;
		vcw_word_t trim_nxt;

		// Next words of this rail.
		always_comb begin
			cmd_nxt = cmd_r[g];
			trim_nxt = trim_r[g];
			if (wrRail[g] && (wrSel == VCW_SEL_CMD)) begin
				cmd_nxt = wrData;
			end
			if (wrRail[g] && (wrSel == VCW_SEL_TRIM)) begin
				trim_nxt = wrData;
			end
		end

		// Word registers of this rail.
		always_ff @(posedge mclk) begin
			if (srst) begin
				cmd_r[g] <= `VCW_CMD_RST;
				trim_r[g] <= `VCW_TRIM_RST;
			end else begin
				cmd_r[g] <= cmd_nxt;
				trim_r[g] <= trim_nxt;
			end
		end

		assign cmdWord[g] = cmd_r[g];
		assign trimWord[g] = trim_r[g];
	end

	// Read data are captured one edge after the request.
	always_comb begin
		rdData_nxt = rdData_r;
		if (rdEn) begin
			rdData_nxt = (rdSel == VCW_SEL_CMD) ? cmd_r[rdRail] :
				trim_r[rdRail];
		end
	end

	// Registered read port.
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdData_r <= 16'h0000;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end

	assign rdData = rdData_r;

endmodule : vcw_rail_store

// ### vcw_target_calc.sv
// Turns one rail's commanded voltage and trim into a bounded target.
// Assumes the limits and operation byte are held stable by their owners.
`timescale 1ns/1ps

module vcw_target_calc
	import vcw_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire vcw_word_t cmdMv,
	input wire vcw_word_t trimMv,
	input wire vcw_word_t minMv,
	input wire vcw_word_t maxMv,
	input wire vcw_byte_t operation,
	output vcw_word_t target,
	output logic useCmd
);

	localparam vcw_word_t TrimLim = `VCW_TRIM_LIM;

	vcw_word_t target_r;
	vcw_word_t target_nxt;
	logic useCmd_r;
	logic useCmd_nxt;
	vcw_word_t trimSat;
	logic signed [17:0] sum;

	// Saturate the trim, add it, then hold the sum inside the limits.
	always_comb begin
		trimSat = trimMv;
		if ($signed(trimMv) > $signed(TrimLim)) begin
			trimSat = TrimLim;
		end else if ($signed(trimMv) < -$signed(TrimLim)) begin
			trimSat = 16'(-$signed(TrimLim));
		end
		sum = $signed({2'b00, cmdMv}) +
			$signed({{2{trimSat[15]}}, trimSat});
		target_nxt = sum[15:0];
		if (sum < $signed({2'b00, minMv})) begin
			target_nxt = minMv;
		end
		if (sum > $signed({2'b00, maxMv})) begin
			target_nxt = maxMv;
		end
		useCmd_nxt = (operation[`VCW_OP_SRC_HI:`VCW_OP_SRC_LO] ==
			`VCW_SRC_CMD);
	end

	// Registered target and source flag.
	always_ff @(posedge mclk) begin
		if (srst) begin
			target_r <= 16'h0000;
			useCmd_r <= 1'b0;
		end else begin
			target_r <= target_nxt;
			useCmd_r <= useCmd_nxt;
		end
	end

	assign target = target_r;
	assign useCmd = useCmd_r;

endmodule : vcw_target_calc

// ### vcw_host_model.sv
// Host model that issues commands and owns page, operation and limits.
// Assumes one clock; it changes its lines 1 ns after a rising edge.
`timescale 1ns/1ps

module vcw_host_model
	import vcw_pkg::*;
(
	input wire logic mclk,
	output logic cmdValid,
	output logic cmdWrite,
	output vcw_byte_t cmdCode,
	output vcw_word_t cmdData,
	output vcw_byte_t pageSel,
	output vcw_byte_t operation0,
	output vcw_byte_t operation1,
	output vcw_word_t voutMin,
	output vcw_word_t voutMax
);
	// Idle request lines and far-side settings from time zero.
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'hFF;
		cmdData = 16'hFFFF;
		pageSel = 8'h00;
		operation0 = 8'h00;
		operation1 = 8'h00;
		voutMin = 16'h0100;
		voutMax = 16'h08FC;
	end

	// Holds one request over its taking edge, returns after the answer.
	task automatic xfer(input logic wr, input vcw_byte_t c,
		input vcw_word_t d);
		@(posedge mclk);
		#1;
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdCode = c;
		cmdData = d;
		@(posedge mclk);
		#1;
		cmdValid = 1'b0;
		cmdWrite = ~wr;
		cmdCode = ~c;
		cmdData = ~d;
		@(posedge mclk);
		#1;
	endtask : xfer

endmodule : vcw_host_model

// ### vcw_regs_properties.sv
// Checker of the command register slice, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module vcw_regs_properties
	import vcw_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire vcw_byte_t cmdCode,
	input wire vcw_word_t cmdData,
	input wire vcw_byte_t pageSel,
	input wire vcw_byte_t operation0,
	input wire vcw_word_t voutMax0,
	input wire logic rspValid,
	input wire vcw_word_t rspData,
	input wire logic wrAccepted,
	input wire logic wrRejected,
	input wire logic invalidDataFault,
	input wire vcw_byte_t protLevel,
	input wire vcw_word_t target0,
	input wire logic targetUse0
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// A write request, and a refusal two edges after it.
	sequence s_wr;
		cmdValid && cmdWrite;
	endsequence
	sequence s_rej;
		##2 rspValid && wrRejected;
	endsequence

	// Every request is answered two edges after it is taken.
	property p_answer;
		cmdValid |-> ##2 rspValid;
	endproperty
	a_answer: assert property (p_answer) else $error("answer late");
	property p_lock;
		s_wr ##0 (protLevel == 8'h40 && cmdCode == 8'h21) |-> s_rej;
	endproperty
	a_lock: assert property (p_lock) else $error("lock write taken");
	property p_cfg;
		s_wr ##0 (protLevel == 8'h20 && cmdCode == 8'h24) |-> s_rej;
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg write taken");
	property p_open;
		s_wr ##0 (protLevel == 8'h00 && cmdCode == 8'h21 && pageSel == 8'h00)
			|-> ##2 rspValid && wrAccepted;
	endproperty
	a_open: assert property (p_open) else $error("open write refused");
	property p_fault;
		s_wr ##0 (cmdCode == 8'h10 && !(cmdData[7:0] inside
			{8'h00, 8'h20, 8'h40})) |-> ##2 invalidDataFault && wrRejected;
	endproperty
	a_fault: assert property (p_fault) else $error("no data fault");
	property p_mode;
		cmdValid && !cmdWrite && cmdCode == 8'h20 |-> ##2 rspData == 16'h0040;
	endproperty
	a_mode: assert property (p_mode) else $error("format value wrong");
	property p_keep;
		s_wr ##0 (cmdCode == 8'h10 && !(cmdData[7:0] inside
			{8'h00, 8'h20, 8'h40})) |-> ##1 $stable(protLevel) [*2];
	endproperty
	a_keep: assert property (p_keep) else $error("level changed");
	property p_use;
		!$past(srst) |-> targetUse0 == (($past(operation0) & 8'h30) == 8'h00);
	endproperty
	a_use: assert property (p_use) else $error("source flag wrong");
	property p_max;
		!$past(srst) && $stable(voutMax0) |-> target0 <= voutMax0;
	endproperty
	a_max: assert property (p_max) else $error("target above max");

endmodule : vcw_regs_properties

bind vcw_regs vcw_regs_properties u_props (.*);

// ### vout_command_write_protect_regs_tb_top.sv
// Self-checking bench of the command register slice.
// Assumes the host model drives every command and setting input.
`timescale 1ns/1ps

module vout_command_write_protect_regs_tb_top;
	import vcw_pkg::*;

	logic mclk, srst, cmdValid, cmdWrite, rspValid, rspHit, wrAccepted;
	logic wrRejected, invalidDataFault, targetUse0, targetUse1;
	vcw_byte_t cmdCode, pageSel, operation0, operation1, protLevel;
	vcw_word_t cmdData, voutMin, voutMax, rspData, target0, target1;
	int n_fail = 0, checks = 0, cyc = 0;
	vcw_byte_t bad [3] = '{8'h01, 8'h33, 8'hFF};

	vcw_host_model host (.mclk(mclk), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.pageSel(pageSel), .operation0(operation0), .operation1(operation1),
		.voutMin(voutMin), .voutMax(voutMax));
	vcw_regs dut (.mclk(mclk), .srst(srst), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.pageSel(pageSel), .operation0(operation0), .operation1(operation1),
		.voutMin0(voutMin), .voutMin1(voutMin), .voutMax0(voutMax),
		.voutMax1(voutMax), .rspValid(rspValid), .rspData(rspData),
		.rspHit(rspHit), .wrAccepted(wrAccepted), .wrRejected(wrRejected),
		.invalidDataFault(invalidDataFault), .protLevel(protLevel),
		.target0(target0), .target1(target1), .targetUse0(targetUse0),
		.targetUse1(targetUse1));

	// Clock of 25 ns period.
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Prints counts and verdict, then stops.
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write with expected outcome; a refused level write must fault.
	// The hit flag must be set only for the four codes of this slice.
	task automatic wr(input vcw_byte_t c, input vcw_word_t d, input logic a);
		host.xfer(1'b1, c, d);
		chk({12'h000, rspValid, rspHit, wrAccepted, wrRejected,
			invalidDataFault}, {12'h000, 1'b1,
			(c inside {8'h10, 8'h20, 8'h21, 8'h22}), a, ~a,
			(c == 8'h10) && !a});
	endtask : wr

	// Read with expected data.
	task automatic rd(input vcw_byte_t c, input vcw_word_t d);
		host.xfer(1'b0, c, 16'h0000);
		chk({rspValid, rspData}, {1'b1, d});
		chk({16'h0000, rspHit},
			{16'h0000, (c inside {8'h10, 8'h20, 8'h21, 8'h22})});
	endtask : rd

	// Cuts a hang short.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			$display("[FAIL] %0t cycle limit reached", $time);
			close_out();
		end
	end

	// Main sequence of tests.
	initial begin
		srst = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		srst = 1'b0;
		rd(8'h10, 16'h0000);
		rd(8'h20, 16'h0040);
		rd(8'h21, 16'h0384);
		rd(8'h22, 16'h0000);
		chk({1'b0, target0}, {1'b0, 16'h0384});
		$display("test reset done");
		host.pageSel = 8'h01;
		wr(8'h21, 16'h0500, 1'b1);
		chk({1'b0, target1}, {1'b0, 16'h0500});
		host.pageSel = 8'h00;
		rd(8'h21, 16'h0384);
		host.pageSel = 8'hFF;
		wr(8'h22, 16'h0010, 1'b1);
		host.pageSel = 8'h01;
		rd(8'h22, 16'h0010);
		chk({1'b0, target0}, {1'b0, 16'h0394});
		host.pageSel = 8'h00;
		wr(8'h22, 16'hFFF6, 1'b1);
		chk({1'b0, target0}, {1'b0, 16'h037A});
		wr(8'h21, 16'h0050, 1'b1);
		chk({1'b0, target0}, {1'b0, 16'h0100});
		wr(8'h21, 16'h0384, 1'b1);
		wr(8'h22, 16'h0200, 1'b1);
		chk({1'b0, target0}, {1'b0, 16'h047E});
		wr(8'h22, 16'hFE00, 1'b1);
		chk({1'b0, target0}, {1'b0, 16'h028A});
		wr(8'h21, 16'h0A00, 1'b1);
		chk({1'b0, target0}, {1'b0, 16'h08FC});
		host.pageSel = 8'h02;
		wr(8'h21, 16'h0700, 1'b0);
		host.pageSel = 8'h00;
		rd(8'h21, 16'h0A00);
		wr(8'h20, 16'h0055, 1'b0);
		rd(8'h20, 16'h0040);
		$display("test rails done");
		foreach (bad[i]) wr(8'h10, {8'h00, bad[i]}, 1'b0);
		rd(8'h10, 16'h0000);
		wr(8'h10, 16'h0020, 1'b1);
		chk({9'h000, protLevel}, {9'h000, 8'h20});
		wr(8'h21, 16'h0400, 1'b1);
		wr(8'h02, 16'h0016, 1'b1);
		wr(8'h24, 16'h08FC, 1'b0);
		wr(8'h10, 16'h0040, 1'b1);
		wr(8'h21, 16'h0600, 1'b0);
		rd(8'h21, 16'h0400);
		wr(8'h22, 16'h0000, 1'b0);
		wr(8'h02, 16'h0016, 1'b0);
		wr(8'h00, 16'h0000, 1'b1);
		wr(8'h01, 16'h0000, 1'b1);
		wr(8'h03, 16'h0000, 1'b1);
		wr(8'h10, 16'h0000, 1'b1);
		wr(8'h24, 16'h08FC, 1'b1);
		$display("test protection done");
		host.operation0 = 8'h10;
		repeat (2) @(posedge mclk);
		#1;
		chk({15'h0000, targetUse0, targetUse1}, 17'h00001);
		$display("test source done");
		close_out();
	end

endmodule : vout_command_write_protect_regs_tb_top
